/* rtl/fps_sequencer.sv */
// host-side erase and program sequencer driving a 32K x 8 flash
`timescale 1ns/10ps
module fps_sequencer
  import fps_pkg::*;
#(
  parameter int              ERASE_CYC = ERASE_PULSE_CYC,
  parameter logic [ADDR_W-1:0] LAST_ADDR = '1,
  parameter int              MAX_TRY   = MAX_PROG_TRY
)(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // user command port
  input  wire logic              start_erase,
  input  wire logic              start_prog,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [7:0]        prog_data,
  output logic                   busy,
  output logic                   done,
  output logic                   fail,
  output logic [ADDR_W-1:0]      fail_addr,
  // flash pins
  output logic                   fl_vpp_en,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [7:0]             fl_dq_out,
  output logic                   fl_dq_oe_n,
  input  wire logic [7:0]        fl_dq_in,
  output logic                   fl_ce_n,
  output logic                   fl_we_n,
  output logic                   fl_oe_n
);
  fps_state_e        state;
  logic [15:0]       wr_gap;     // cycles since a write strobe was low
  logic              rd_ok;
  logic              erase_job;
  logic [ADDR_W-1:0] cur_addr;
  logic [7:0]        cur_data;
  logic [4:0]        tries;
  logic              bus_req;
  fps_op_e           bus_op;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0]        bus_wdata;
  logic              bus_ack;
  logic [7:0]        bus_rdata;
  logic              dly_start;
  logic [CNT_W-1:0]  dly_cycles;
  logic              dly_done;
  logic              waiting;

  // states that issue one bus write or read
  function automatic logic wants_bus(input fps_state_e s);
    case (s)
      FPS_ZERO_SETUP, FPS_ZERO_DATA, FPS_PGM_VFY, FPS_PGM_READ,
      FPS_ER_SETUP, FPS_ER_GO, FPS_ER_VFY, FPS_ER_READ,
      FPS_ABORT1, FPS_ABORT2, FPS_TO_READ: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // states whose step ends on the delay counter
  function automatic logic is_timed(input fps_state_e s);
    return (s == FPS_VPP_UP) || (s == FPS_PGM_WAIT) ||
           (s == FPS_ER_WAIT);
  endfunction

  fps_bus_cycle u_bus (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .clk_en     (clk_en),
    .req        (bus_req),
    .op         (bus_op),
    .addr       (bus_addr),
    .wdata      (bus_wdata),
    .ack        (bus_ack),
    .rdata      (bus_rdata),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_dq_in   (fl_dq_in),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n)
  );

  fps_delay #(.W(CNT_W)) u_dly (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (dly_start),
    .cycles  (dly_cycles),
    .done    (dly_done)
  );

  // bus request decode per state
  always_comb
  begin
    bus_req   = wants_bus(state);
    bus_op    = FPS_OP_WRITE;
    bus_addr  = cur_addr;
    bus_wdata = CMD_READ;
    case (state)
      FPS_ZERO_SETUP: bus_wdata = CMD_PROGRAM;
      FPS_ZERO_DATA:  bus_wdata = cur_data;
      FPS_PGM_VFY:    bus_wdata = CMD_PROG_VF;
      FPS_ER_SETUP:   bus_wdata = CMD_ERASE;
      FPS_ER_GO:      bus_wdata = CMD_ERASE;
      FPS_ER_VFY:     bus_wdata = CMD_ERASE_VF;
      FPS_ABORT1:     bus_wdata = CMD_RESET;
      FPS_ABORT2:     bus_wdata = CMD_RESET;
      FPS_PGM_READ:   bus_op    = FPS_OP_READ;
      FPS_ER_READ:    bus_op    = FPS_OP_READ;
      default:        bus_wdata = CMD_READ;
    endcase
    // no output enable until write recovery has passed
    if (bus_op == FPS_OP_READ && !rd_ok)
      bus_req = 1'b0;
  end

  // delay length per timed state; the strobe hold already gave one
  // high phase, so the program and erase waits below add to it and count from the ack at the end of the hold
  always_comb
  begin
    case (state)
      FPS_VPP_UP:   dly_cycles = CNT_W'(VPP_SETUP_CYC);
      FPS_PGM_WAIT: dly_cycles = CNT_W'(PROG_PULSE_CYC);
      FPS_ER_WAIT:  dly_cycles = CNT_W'(ERASE_CYC);
      default:      dly_cycles = CNT_W'(1);
    endcase
  end
  assign dly_start = is_timed(state) && !waiting;
  assign busy      = (state != FPS_IDLE);
  assign rd_ok     = (32'(wr_gap) >= WR_TO_OE_CYC);

  // write recovery timer; saturates so a long idle never wraps,
  // at no cost to verify reads, each of which follows a write that clears it
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wr_gap <= '1;
    else if (clk_en)
    begin
      if (!fl_we_n)
        wr_gap <= 16'h0000;
      else if (wr_gap != '1)
        wr_gap <= wr_gap + 16'h0001;
    end
  end

  // arm the delay once on entry to a timed state
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      waiting <= 1'b0;
    else if (clk_en)
    begin
      if (!is_timed(state) || dly_done)
        waiting <= 1'b0;
      else
        waiting <= 1'b1;
    end
  end

  // main algorithm
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= FPS_IDLE;
      erase_job <= 1'b0;
      cur_addr  <= '0;
      cur_data  <= 8'h00;
      tries     <= 5'h00;
      done      <= 1'b0;
      fail      <= 1'b0;
      fail_addr <= '0;
      fl_vpp_en <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      case (state)
        FPS_IDLE:
          if (start_erase || start_prog)
          begin
            fail      <= 1'b0;
            erase_job <= start_erase;
            // erase begins by zeroing the array from the bottom
            cur_addr  <= start_erase ? FIRST_ADDR : prog_addr;
            cur_data  <= start_erase ? ZERO_BYTE : prog_data;
            tries     <= 5'h00;
            fl_vpp_en <= 1'b1;
            state     <= FPS_VPP_UP;
          end
        FPS_VPP_UP:
          if (dly_done)
            state <= FPS_ZERO_SETUP;
        FPS_ZERO_SETUP:
          if (bus_ack)
            state <= FPS_ZERO_DATA;
        FPS_ZERO_DATA:
          if (bus_ack)
          begin
            tries <= tries + 5'h01;
            state <= FPS_PGM_WAIT;
          end
        FPS_PGM_WAIT:
          if (dly_done)
            state <= FPS_PGM_VFY;
        FPS_PGM_VFY:
          if (bus_ack)
            state <= FPS_PGM_READ;  // pulse ends here
        FPS_PGM_READ:
          if (bus_ack)
            state <= FPS_PGM_CHECK;  // read held off
        FPS_PGM_CHECK:
          if (bus_rdata == cur_data)
          begin
            tries <= 5'h00;
            if (!erase_job)
              state <= FPS_TO_READ;
            else if (cur_addr == LAST_ADDR)
            begin
              cur_addr <= FIRST_ADDR;
              state    <= FPS_ER_SETUP;
            end
            else
            begin
              cur_addr <= cur_addr + ADDR_W'(1);
              state    <= FPS_ZERO_SETUP;
            end
          end
          else if (32'(tries) >= MAX_TRY)
          begin
            fail      <= 1'b1;
            fail_addr <= cur_addr;
            state     <= FPS_ABORT1;
          end
          else
            state <= FPS_ZERO_SETUP;
        FPS_ER_SETUP:
          if (bus_ack)
            state <= FPS_ER_GO;  // arm only
        FPS_ER_GO:
          if (bus_ack)
            state <= FPS_ER_WAIT;
        FPS_ER_WAIT:
          if (dly_done)
            state <= FPS_ER_VFY;
        FPS_ER_VFY:
          if (bus_ack)
            state <= FPS_ER_READ;  // erase ends here
        FPS_ER_READ:
          if (bus_ack)
            state <= FPS_ER_CHECK;
        FPS_ER_CHECK:
          if (bus_rdata != ERASED_BYTE)
            state <= FPS_ER_SETUP;  // cur_addr kept
          else if (cur_addr == LAST_ADDR)
            state <= FPS_TO_READ;
          else
          begin
            cur_addr <= cur_addr + ADDR_W'(1);
            state    <= FPS_ER_VFY;
          end
        FPS_ABORT1:
          if (bus_ack)
            state <= FPS_ABORT2;
        FPS_ABORT2:
          if (bus_ack)
            state <= FPS_TO_READ;
        FPS_TO_READ:
          if (bus_ack)
            state <= FPS_DONE;
        FPS_DONE:
        begin
          fl_vpp_en <= 1'b0;
          done      <= 1'b1;
          state     <= FPS_IDLE;
        end
        default: state <= FPS_IDLE;
      endcase
    end
  end
endmodule

/* rtl/fps_pkg.sv */
// package: flash sequencer command codes, timing figures and cycle counts
package fps_pkg;
  // command codes written to the memory's command register
  localparam logic [7:0] CMD_READ     = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h20;
  localparam logic [7:0] CMD_ERASE_VF = 8'ha0;
  localparam logic [7:0] CMD_PROGRAM  = 8'h40;
  localparam logic [7:0] CMD_PROG_VF  = 8'hc0;
  localparam logic [7:0] CMD_RESET    = 8'hff;
  // data values
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [14:0] FIRST_ADDR  = 15'h0000;
  // geometry and retry limit
  localparam int ADDR_W        = 15;
  localparam int MAX_PROG_TRY  = 25;
  // clock
  localparam int CLK_MHZ       = 40;
  // times in their own units, as printed
  localparam int PROG_PULSE_NS  = 9500;     // program_pulse_time, least
  localparam int ERASE_PULSE_NS = 9500000;  // erase_pulse_time, least
  localparam int WR_TO_OE_NS    = 6000;     // strobe end to output enable
  localparam int VPP_SETUP_NS   = 100;      // supply high to first strobe
  localparam int STROBE_NS      = 100;      // write pulse width used
  localparam int STROBE_HIGH_NS = 100;      // strobe high between writes
  localparam int READ_NS        = 200;      // output enable to sample
  // least times except the erase pulse round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int PROG_PULSE_CYC  = ns_to_cyc(PROG_PULSE_NS);
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS / 1000) * CLK_MHZ;
  localparam int WR_TO_OE_CYC    = ns_to_cyc(WR_TO_OE_NS);
  localparam int VPP_SETUP_CYC   = ns_to_cyc(VPP_SETUP_NS);
  localparam int STROBE_CYC      = ns_to_cyc(STROBE_NS);
  localparam int STROBE_HIGH_CYC = ns_to_cyc(STROBE_HIGH_NS);
  localparam int READ_CYC        = ns_to_cyc(READ_NS);
  localparam int CNT_W           = 24;
  // controller states
  typedef enum logic [4:0] {
    FPS_IDLE, FPS_VPP_UP, FPS_ZERO_SETUP, FPS_ZERO_DATA,
    FPS_PGM_WAIT, FPS_PGM_VFY, FPS_PGM_READ, FPS_PGM_CHECK,
    FPS_ER_SETUP, FPS_ER_GO, FPS_ER_WAIT, FPS_ER_VFY, FPS_ER_READ,
    FPS_ER_CHECK, FPS_ABORT1, FPS_ABORT2, FPS_TO_READ, FPS_DONE
  } fps_state_e;
  // bus operation requested of the cycle engine
  typedef enum logic [1:0] {FPS_OP_WRITE, FPS_OP_READ} fps_op_e;
endpackage

/* rtl/fps_delay.sv */
// delay counter: counts a loaded number of cycles then pulses done
`timescale 1ns/10ps
module fps_delay
  import fps_pkg::*;
#(
  parameter int W = CNT_W
)(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] cycles,
  output logic              done
);
  logic [W-1:0] count;
  logic         busy;

  // one-shot: done pulses in the cycle the count expires
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= cycles;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (count <= W'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count <= count - W'(1);
      end
    end
  end
endmodule

/* rtl/fps_bus_cycle.sv */
// bus cycle engine: one write or read cycle on the flash pins
`timescale 1ns/10ps
module fps_bus_cycle
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // request from the sequencer
  input  wire logic              req,
  input  wire fps_op_e           op,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic                   ack,
  output logic [7:0]             rdata,
  // flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [7:0]             fl_dq_out,
  output logic                   fl_dq_oe_n,
  input  wire logic [7:0]        fl_dq_in,
  output logic                   fl_ce_n,
  output logic                   fl_we_n,
  output logic                   fl_oe_n
);
  typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_HOLD} fps_bc_e;
  fps_bc_e     bc;
  logic [7:0]  cnt;
  logic        is_rd;

  // ce and we fall together; we is the governing strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bc         <= BC_IDLE;
      cnt        <= 8'h00;
      is_rd      <= 1'b0;
      ack        <= 1'b0;
      rdata      <= 8'h00;
      fl_addr    <= '0;
      fl_dq_out  <= 8'h00;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
    end
    else if (clk_en)
    begin
      ack <= 1'b0;
      case (bc)
        BC_IDLE:
          if (req && !ack)
          begin
            fl_addr <= addr;
            is_rd   <= (op == FPS_OP_READ);
            fl_ce_n <= 1'b0;
            cnt     <= 8'(op == FPS_OP_READ ? READ_CYC : STROBE_CYC);
            if (op == FPS_OP_READ)
              fl_oe_n <= 1'b0;
            else
            begin
              fl_we_n    <= 1'b0;
              fl_dq_out  <= wdata;
              fl_dq_oe_n <= 1'b0;
            end
            bc <= BC_STROBE;
          end
        BC_STROBE:
          if (cnt <= 8'h01)
          begin
            // rising strobe edge latches the data
            if (is_rd)
              rdata <= fl_dq_in;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            cnt     <= 8'(STROBE_HIGH_CYC);
            bc      <= BC_HOLD;
          end
          else
            cnt <= cnt - 8'h01;
        BC_HOLD:
          if (cnt <= 8'h01)
          begin
            fl_dq_oe_n <= 1'b1;
            ack        <= 1'b1;
            bc         <= BC_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        default: bc <= BC_IDLE;
      endcase
    end
  end
endmodule

/* bench/fps_sequencer_checker.sv */
// checker: strobe timing and command order at the flash pins
`timescale 1ns/10ps
module fps_seq_checker
  import fps_pkg::*;
#(
  parameter int                ERASE_CYC = ERASE_PULSE_CYC,
  parameter logic [ADDR_W-1:0] LAST_ADDR = '1,
  parameter int                MAX_TRY   = MAX_PROG_TRY
)(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              resetn,
  // flash pins
  input wire logic              fl_vpp_en,
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [7:0]        fl_dq_out,
  input wire logic              fl_dq_oe_n,
  input wire logic              fl_ce_n,
  input wire logic              fl_we_n,
  input wire logic              fl_oe_n
);
  logic        we_q;
  logic        wr_fall;
  logic        prog_dat;
  logic [7:0]  last_cmd;
  logic [23:0] hi_cnt;
  logic [5:0]  tries;
  logic [ADDR_W-1:0] try_addr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  assign wr_fall = we_q && !fl_we_n;
  // idle strobe time, saturating so long waits never wrap
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      hi_cnt <= '0;
    else if (!fl_we_n)
      hi_cnt <= '0;
    else if (hi_cnt != '1)
      hi_cnt <= hi_cnt + 1'b1;
  // last command, skipping the data write that follows 40h
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      we_q     <= 1'b1;
      prog_dat <= 1'b0;
      last_cmd <= '0;
      tries    <= '0;
      try_addr <= '0;
    end
    else
    begin
      we_q <= fl_we_n;
      if (wr_fall)
      begin
        prog_dat <= !prog_dat && fl_dq_out == CMD_PROGRAM;
        if (!prog_dat)
          last_cmd <= fl_dq_out;
        if (prog_dat)
        begin
          // a new byte address starts its own try count
          try_addr <= fl_addr;
          if (fl_addr != try_addr)
            tries <= 6'h01;
        end
        else if (fl_dq_out == CMD_PROGRAM)
          tries <= tries + 1'b1;
        else if (fl_dq_out != CMD_PROG_VF)
          tries <= '0;
      end
    end
  sequence s_wr(logic [7:0] c);
    wr_fall && !prog_dat && fl_dq_out == c;
  endsequence
  property p_we_ce;
    $fell(fl_we_n) |-> !fl_ce_n;
  endproperty
  a_we_ce: assert property (p_we_ce)
    else $error("write strobe without chip enable");
  property p_wr_width;
    $fell(fl_we_n) |-> (!fl_we_n && !fl_ce_n) [*4] ##1 (fl_we_n && fl_ce_n);
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width wrong");
  property p_vpp_setup;
    $fell(fl_we_n) |-> $past(fl_vpp_en, 4);
  endproperty
  a_vpp_setup: assert property (p_vpp_setup)
    else $error("strobe too soon after supply rise");
  property p_rd_width;
    $fell(fl_oe_n) |-> (!fl_oe_n && !fl_ce_n && fl_we_n) [*8] ##1 fl_oe_n;
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("verify read cycle wrong");
  property p_prog_gap;
    s_wr(CMD_PROG_VF) |-> hi_cnt >= PROG_PULSE_CYC;
  endproperty
  a_prog_gap: assert property (p_prog_gap)
    else $error("program pulse ended early");
  property p_erase_gap;
    s_wr(CMD_ERASE_VF) ##0 last_cmd == CMD_ERASE |-> hi_cnt >= ERASE_CYC;
  endproperty
  a_erase_gap: assert property (p_erase_gap)
    else $error("erase ended early");
  property p_erase_pair;
    s_wr(CMD_ERASE) ##0 last_cmd != CMD_ERASE |-> ##[1:30] s_wr(CMD_ERASE);
  endproperty
  a_erase_pair: assert property (p_erase_pair)
    else $error("erase set-up not repeated");
  property p_try_limit;
    tries <= MAX_TRY;
  endproperty
  a_try_limit: assert property (p_try_limit)
    else $error("too many program tries");
  property p_rd_gap;
    $fell(fl_oe_n) |-> hi_cnt >= WR_TO_OE_CYC;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("output enable too soon after write");
  property p_dq_wr;
    !fl_we_n |-> !fl_dq_oe_n;
  endproperty
  a_dq_wr: assert property (p_dq_wr)
    else $error("write strobe without data driven");
  property p_dq_rd;
    !fl_oe_n |-> fl_dq_oe_n;
  endproperty
  a_dq_rd: assert property (p_dq_rd)
    else $error("host drives data during a read");
endmodule

bind fps_sequencer fps_seq_checker #(
  .ERASE_CYC(ERASE_CYC),
  .LAST_ADDR(LAST_ADDR),
  .MAX_TRY(MAX_TRY)
) u_fps_seq_checker (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .fl_vpp_en(fl_vpp_en),
  .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out),
  .fl_dq_oe_n(fl_dq_oe_n),
  .fl_ce_n(fl_ce_n),
  .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n)
);

/* bench/fps_flash_model.sv */
// partner model: command-register flash with slow program and erase
`timescale 1ns/10ps
module fps_flash_model
  import fps_pkg::*;
(
  // clock
  input  wire logic              sys_clk,
  // behaviour knobs
  input  wire logic [5:0]        need_pulses,
  input  wire logic [1:0]        need_erases,
  // flash pins
  input  wire logic              fl_vpp_en,
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [7:0]        fl_dq_out,
  output logic      [7:0]        fl_dq_in,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_we_n,
  input  wire logic              fl_oe_n
);
  logic [7:0] mem [0:3];
  logic [7:0] cmd = '0;
  logic [7:0] rd;
  logic [7:0] last = '0;
  logic [1:0] pa = '0;
  logic [1:0] va = '0;
  logic [5:0] pulses = '0;
  logic [1:0] erases = '0;
  logic       wr_q = 1'b0;
  initial mem = '{default: 8'hff};
  // decode on the rising end of a write; op runs until verify or reset
  always @(posedge sys_clk)
  begin
    wr_q <= !fl_ce_n && !fl_we_n;
    if (!fl_vpp_en)
      cmd <= CMD_READ;
    else if (wr_q && (fl_ce_n || fl_we_n))
    begin
      cmd <= fl_dq_out;
      if (cmd == CMD_PROGRAM)
      begin
        pa     <= fl_addr[1:0];
        pulses <= pulses + 1'b1;
        cmd    <= 8'h01;
        if (pulses + 1 >= need_pulses)
          mem[fl_addr[1:0]] <= mem[fl_addr[1:0]] & fl_dq_out;
      end
      else if (cmd == CMD_ERASE && fl_dq_out == CMD_ERASE)
      begin
        erases <= erases + 1'b1;
        cmd    <= 8'h02;
        // a short erase leaves the upper bytes unerased
        for (int i = 0; i < 4; i++)
          if (erases + 1 >= need_erases || i < 2)
            mem[i] <= ERASED_BYTE;
      end
      else if (cmd == CMD_RESET && fl_dq_out == CMD_RESET)
        cmd <= CMD_READ;
      else
      begin
        if (fl_dq_out == CMD_ERASE_VF)
          va <= fl_addr[1:0];
        if (fl_dq_out == CMD_READ || fl_dq_out == CMD_RESET)
          pulses <= '0;
      end
    end
  end
  // verify reads see only fully programmed cells
  assign rd = (cmd == CMD_ERASE_VF) ? mem[va] :
              (cmd == CMD_PROG_VF) ? mem[pa] : mem[fl_addr[1:0]];
  // released bus shows the inverse, so stale data never passes
  always @(posedge sys_clk)
    if (!fl_ce_n && !fl_oe_n)
      last <= rd;
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~last;
endmodule

/* bench/tb_top.sv */
// testbench: program, retry exhaustion and chip erase jobs
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
  import fps_pkg::*;
;
  logic              sys_clk = 0;
  logic              resetn = 0;
  logic              clk_en = 1'b1;
  logic              start_erase = 0;
  logic              start_prog = 0;
  logic [ADDR_W-1:0] prog_addr = '0;
  logic [7:0]        prog_data = '0;
  logic [5:0]        need_pulses = 6'h01;
  logic [1:0]        need_erases = 2'h1;
  logic              busy, done, fail, fl_vpp_en, fl_dq_oe_n;
  logic              fl_ce_n, fl_we_n, fl_oe_n;
  logic [ADDR_W-1:0] fail_addr, fl_addr;
  logic [7:0]        fl_dq_out, fl_dq_in;
  logic [7:0]        wd[$];
  logic [ADDR_W-1:0] wa[$];
  logic              we_q = 1'b1;
  int                bad_count = 0;
  int                check_count = 0;
  int                cyc = 0;
  fps_sequencer #(.ERASE_CYC(50), .LAST_ADDR(15'h0003)) u_fps_sequencer (
    .sys_clk, .resetn, .clk_en, .start_erase, .start_prog,
    .prog_addr, .prog_data, .busy, .done, .fail, .fail_addr, .fl_vpp_en,
    .fl_addr, .fl_dq_out, .fl_dq_oe_n, .fl_dq_in, .fl_ce_n, .fl_we_n,
    .fl_oe_n);
  fps_flash_model u_fps_flash_model (
    .sys_clk, .need_pulses, .need_erases, .fl_vpp_en, .fl_addr,
    .fl_dq_out, .fl_dq_in, .fl_ce_n, .fl_we_n, .fl_oe_n);
  always #12.5 sys_clk = ~sys_clk;
  // log every write at its latch edge; hangs are cut short
  always @(posedge sys_clk)
  begin
    we_q <= fl_we_n;
    if (fl_we_n && !we_q)
    begin
      wd.push_back(fl_dq_out);
      wa.push_back(fl_addr);
    end
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  function automatic int cnt(input logic [7:0] v);
    cnt = 0;
    foreach (wd[i])
      if (wd[i] === v)
        cnt++;
  endfunction
  task automatic run_job(input logic er, input logic [ADDR_W-1:0] a,
                         input logic [7:0] d, input int frz = 0);
    int n;
    wd.delete();
    wa.delete();
    start_erase = er;
    start_prog = !er;
    prog_addr = a;
    prog_data = d;
    @(negedge sys_clk);
    start_erase = 0;
    start_prog = 0;
    `CHK({busy, fl_vpp_en}, 2'h3)
    if (frz > 0)
    begin
      // frozen clock enable: supply stays up, no strobe may start
      clk_en = 1'b0;
      repeat (frz) @(negedge sys_clk);
      `CHK({busy, fl_vpp_en, fl_we_n, wd.size() == 0}, 4'hf)
      clk_en = 1'b1;
    end
    n = 0;
    while (done !== 1'b1 && n < 30000)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(done, 1'b1)
    `CHK({busy, fl_vpp_en}, 2'h0)
    @(negedge sys_clk);
  endtask
  task automatic t_idle();
    `CHK({fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe_n, fl_vpp_en}, 5'h1e)
  endtask
  task automatic t_prog_retry();
    need_pulses = 6'h03;
    run_job(1'b0, 15'h0001, 8'h5a, 40);
    `CHK(wd[0], CMD_PROGRAM)
    `CHK({wa[1], wd[1]}, {15'h0001, 8'h5a})
    `CHK(cnt(CMD_PROGRAM), 3)
    `CHK(cnt(CMD_PROG_VF), 3)
    `CHK(u_fps_flash_model.mem[1], 8'h5a)
    `CHK(fail, 1'b0)
  endtask
  task automatic t_exhaust();
    need_pulses = 6'h28;
    run_job(1'b0, 15'h0002, 8'h00);
    `CHK(cnt(CMD_PROGRAM), MAX_PROG_TRY)
    `CHK({fail, fail_addr}, {1'b1, 15'h0002})
    `CHK(wd[wd.size() - 3], CMD_RESET)
    `CHK(wd[wd.size() - 2], CMD_RESET)
    `CHK(wd[wd.size() - 1], CMD_READ)
  endtask
  task automatic t_erase();
    logic [3:0]        z;
    logic [ADDR_W-1:0] ev[$];
    logic [ADDR_W-1:0] exp_ev[5];
    int                e;
    exp_ev = '{15'h0, 15'h1, 15'h2, 15'h2, 15'h3};
    need_pulses = 6'h01;
    need_erases = 2'h2;
    run_job(1'b1, 15'h0000, 8'h00);
    z = '0;
    e = 0;
    while (e < wd.size() && wd[e] !== CMD_ERASE)
      e++;
    for (int i = 0; i + 1 < e; i++)
      if (wd[i] === CMD_PROGRAM && wd[i + 1] === ZERO_BYTE)
        z[wa[i + 1][1:0]] = 1'b1;
    `CHK(z, 4'hf)
    `CHK(cnt(CMD_ERASE), 4)
    foreach (wd[i])
      if (wd[i] === CMD_ERASE_VF)
        ev.push_back(wa[i]);
    `CHK(ev.size(), 5)
    foreach (ev[i])
      `CHK(ev[i], exp_ev[i])
    for (int i = 0; i < 4; i++)
      `CHK(u_fps_flash_model.mem[i], ERASED_BYTE)
    `CHK(fail, 1'b0)
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    t_idle();
    resetn = 1'b1;
    @(negedge sys_clk);
    t_prog_retry();
    t_exhaust();
    t_erase();
    wrap_up();
  end
endmodule
